/* File: bench/pspt_meas_src.sv */
`timescale 1ns/10ps
module pspt_meas_src
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// commands
	input wire logic [pspt_pkg::MEAS_W-1:0] setMeas,
	input wire logic [pspt_pkg::FAULT_W-1:0] setFault,
	input wire logic setBlock,
	// to stage
	output logic [pspt_pkg::MEAS_W-1:0] measMag,
	output logic [pspt_pkg::FAULT_W-1:0] faultType,
	output logic blockIn
);
	import pspt_pkg::*;
	// registered so levels never move inside a sampling step
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			measMag <= '0;
			faultType <= '0;
			blockIn <= 1'b0;
		end
		else
		begin
			measMag <= setMeas;
			faultType <= setFault;
			// bench raises it two clocks after a tick, well before the next one
			blockIn <= setBlock;
		end
	end
endmodule : pspt_meas_src

/* File: bench/pspt_stage_props.sv */
`timescale 1ns/10ps
module pspt_stage_props
#(
	parameter int CYCLE_CLKS_P = 10
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// stage link
	input wire logic blockIn,
	input wire logic startOut,
	input wire logic tripOut,
	input wire logic blockedOut,
	input wire logic cycleTick,
	input wire logic evtValid,
	// bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	trip_needs_start_a: assert property (tripOut |-> startOut)
		else $error("trip without start");
	start_block_excl_a: assert property (!(startOut && blockedOut))
		else $error("start and blocked together");
	outputs_on_tick_a: assert property (
		$changed({startOut, tripOut, blockedOut}) |-> $past(cycleTick))
		else $error("stage output moved off tick");
	block_event_a: assert property ($rose(blockedOut) |-> evtValid)
		else $error("no event on blocking");
	event_pulse_a: assert property (evtValid |=> !evtValid)
		else $error("event longer than one cycle");
	block_clears_a: assert property (
		cycleTick && blockIn |=> !startOut && !tripOut)
		else $error("start survived blocking");
	unblock_release_a: assert property (
		cycleTick && !blockIn |=> !blockedOut)
		else $error("blocked without blocking");
	bus_answer_a: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer out of time");
	cover property ($rose(tripOut));
	cover property ($rose(blockedOut));
	cover property ($fell(startOut) && !tripOut);
endmodule : pspt_stage_props
bind pspt_stage pspt_stage_props #(.CYCLE_CLKS_P(CYCLE_CLKS_P)) props (
	.core_clk(core_clk), .resetn(resetn), .blockIn(blockIn),
	.startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
	.cycleTick(cycleTick), .evtValid(evtValid), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

/* File: bench/pspt_stage_tb.sv */
`timescale 1ns/10ps
module pspt_stage_tb;
	import pspt_pkg::*;
	typedef struct {logic [1:0] c; logic [31:0] d; logic [15:0] m;
		logic [31:0] t;} pspt_row_t;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] setMeas = '0;
	logic [3:0] setFault = '0;
	logic setBlock = 1'b0;
	logic [15:0] measMag;
	logic [3:0] faultType;
	logic blockIn, startOut, tripOut, blockedOut, cycleTick, evtValid, irq;
	logic avs_waitrequest;
	logic [31:0] evtTime, avs_readdata, rd, cnt;
	logic [15:0] evtMeas;
	logic [3:0] evtFault;
	logic [4:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = '0;
	int nErrors = 0;
	int nCompared = 0;
	pspt_row_t rows [8] = '{'{2'h0, 32'h0, 16'h0200, 32'h0},
		'{2'h0, 32'h2, 16'h0200, 32'h2}, '{2'h0, 32'h2, 16'h0800, 32'h2},
		'{2'h2, 32'h2, 16'h0200, 32'h2}, '{2'h1, 32'h0, 16'h0200, 32'h5},
		'{2'h1, 32'h0, 16'h0300, 32'h3}, '{2'h3, 32'h0, 16'h0200, 32'h3},
		'{2'h1, 32'h6, 16'h0300, 32'h6}};
	logic [15:0] hysMeas [4] = '{16'h0100, 16'h0101, 16'h00f9, 16'h00f8};
	logic hysExp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	pspt_meas_src src (.core_clk(core_clk), .resetn(resetn),
		.setMeas(setMeas), .setFault(setFault), .setBlock(setBlock),
		.measMag(measMag), .faultType(faultType), .blockIn(blockIn));
	pspt_stage #(.CYCLE_CLKS_P(10)) dut (.core_clk(core_clk),
		.resetn(resetn), .measMag(measMag), .faultType(faultType),
		.blockIn(blockIn), .startOut(startOut), .tripOut(tripOut),
		.blockedOut(blockedOut), .cycleTick(cycleTick),
		.evtValid(evtValid), .evtTime(evtTime), .evtMeas(evtMeas),
		.evtFault(evtFault), .irq(irq), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic giveVerdict();
		$display("errors %0d compared %0d", nErrors, nCompared);
		if (nErrors == 0 && nCompared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : giveVerdict

	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			nErrors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chkVal

	task automatic chkFlag(input logic got, input logic exp);
		chkVal({31'h0, got}, {31'h0, exp});
	endtask : chkFlag

	task automatic hang();
		nErrors++;
		giveVerdict();
	endtask : hang

	task automatic busOp(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		int i;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		// status clear uses lane 0 only
		avs_byteenable <= (a == REG_IRQ_STAT) ? 4'h1 : 4'hf;
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 20; i++)
		begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 20)
			hang();
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : busOp

	// returns just after the edge that closes a tick cycle
	task automatic waitTick();
		int i;
		for (i = 0; i < 100; i++)
		begin
			@(posedge core_clk);
			if (cycleTick === 1'b1)
				break;
		end
		if (i == 100)
			hang();
		#1;
	endtask : waitTick

	// new source values land well between two ticks
	task automatic applyTick(input logic [15:0] m, input logic b);
		waitTick();
		@(posedge core_clk);
		setMeas <= m;
		setBlock <= b;
		setFault <= 4'h3;
		waitTick();
	endtask : applyTick

	task automatic runRow(input pspt_row_t r);
		int i;
		busOp(1'b1, REG_CTRL, {30'h0, r.c});
		busOp(1'b1, REG_DELAY, r.d);
		applyTick(r.m, 1'b0);
		for (i = 0; i < 20 && startOut !== 1'b1; i++)
			waitTick();
		chkFlag(startOut, 1'b1);
		cnt = '0;
		while (tripOut !== 1'b1 && cnt < 32'h14)
		begin
			waitTick();
			cnt++;
		end
		chkVal(cnt, r.t);
		applyTick(16'h0000, 1'b0);
	endtask : runRow

	initial
	begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		busOp(1'b0, REG_CTRL, '0);
		chkVal(rd, 32'h0);
		busOp(1'b0, REG_DELAY, '0);
		chkVal(rd, 32'h8);
		busOp(1'b1, REG_DELAY, 32'h7ffff);
		busOp(1'b0, REG_DELAY, '0);
		chkVal(rd, {13'h0, DELAY_MAX});
		foreach (rows[k])
			runRow(rows[k]);
		busOp(1'b1, REG_CTRL, '0);
		busOp(1'b1, REG_DELAY, 32'h64);
		foreach (hysMeas[k])
		begin
			applyTick(hysMeas[k], 1'b0);
			chkFlag(startOut, hysExp[k]);
			chkFlag(tripOut, 1'b0);
		end
		busOp(1'b1, REG_IRQ_MASK, 32'h4);
		applyTick(16'h0200, 1'b1);
		chkFlag(blockedOut, 1'b1);
		chkFlag(startOut, 1'b0);
		chkFlag(evtValid, 1'b1);
		chkVal({28'h0, evtFault}, 32'h3);
		chkVal({16'h0, evtMeas}, 32'h200);
		chkFlag(irq, 1'b1);
		// time counter has stepped once since the event tick
		busOp(1'b0, REG_TIME, '0);
		chkVal(rd, evtTime + 32'h1);
		busOp(1'b1, REG_IRQ_STAT, 32'h4);
		busOp(1'b0, REG_IRQ_STAT, '0);
		chkFlag(rd[IRQ_BLOCK_BIT], 1'b0);
		chkFlag(irq, 1'b0);
		applyTick(16'h0200, 1'b0);
		chkFlag(startOut, 1'b1);
		applyTick(16'h0200, 1'b1);
		chkFlag(startOut, 1'b0);
		chkFlag(blockedOut, 1'b1);
		busOp(1'b0, REG_STATE, '0);
		chkVal(rd, 32'h9);
		busOp(1'b1, REG_CTRL, 32'h3);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		chkFlag(blockedOut, 1'b0);
		resetn <= 1'b1;
		busOp(1'b0, REG_CTRL, '0);
		chkVal(rd, 32'h0);
		giveVerdict();
	end
endmodule : pspt_stage_tb

/* File: rtl/pspt_delay_timer.sv */
`timescale 1ns/10ps
module pspt_delay_timer
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// control
	input wire logic tick,
	input wire logic run,
	input wire logic [pspt_pkg::ACC_W-1:0] increment,
	// state
	output logic [pspt_pkg::DELAY_W-1:0] elapsed,
	output logic [pspt_pkg::ACC_W-1:0] acc
);
	import pspt_pkg::*;

	typedef struct packed
	{
		logic [DELAY_W-1:0] elapsed;
		logic [ACC_W-1:0] acc;
	} pspt_timer_t;

	pspt_timer_t s;
	pspt_timer_t next_s;
	logic [ACC_W:0] sum;

	always_comb
	begin
		next_s = s;
		sum = {1'b0, s.acc} + {1'b0, increment};
		if (!run)
		begin
			// dropout clears the running timer
			next_s = '0;
		end
		else if (tick)
		begin
			// saturate so a long hold never wraps to an early trip
			if (s.elapsed != {DELAY_W{1'b1}})
				next_s.elapsed = s.elapsed + 1'b1;
			next_s.acc = sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign elapsed = s.elapsed;
	assign acc = s.acc;
endmodule : pspt_delay_timer

/* File: rtl/pspt_pkg.sv */
package pspt_pkg;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int CYCLE_TIME_US = 5000;
	localparam int CYCLE_CLKS = CYCLE_TIME_US * CLK_MHZ;
	localparam int BLOCK_LEAD_MS = 5;
	localparam int BLOCK_LEAD_CYCLES = (BLOCK_LEAD_MS * 1000) / CYCLE_TIME_US;
	localparam int CYC_W = 32;

	// widths
	localparam int MEAS_W = 16;
	localparam int DELAY_W = 19;
	localparam int ACC_W = 32;
	localparam int TS_W = 32;
	localparam int FAULT_W = 4;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int PCT_W = 7;

	// hysteresis ratio
	localparam logic [PCT_W-1:0] RESET_PCT = 7'h61;
	localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

	// delay in 5 ms steps, 360000 steps = 1800 s
	localparam logic [DELAY_W-1:0] DELAY_MAX = 19'h57e40;
	localparam logic [DELAY_W-1:0] DELAY_RST = 19'h00008;
	localparam logic [MEAS_W-1:0] PICKUP_RST = 16'h0100;
	localparam logic [MEAS_W-1:0] DIAL_RST = 16'h0005;

	// register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_PICKUP = 5'h04;
	localparam logic [ADDR_W-1:0] REG_DELAY = 5'h08;
	localparam logic [ADDR_W-1:0] REG_DIAL = 5'h0c;
	localparam logic [ADDR_W-1:0] REG_STATE = 5'h10;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h14;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h18;
	localparam logic [ADDR_W-1:0] REG_TIME = 5'h1c;

	// field positions
	localparam int CTRL_TYPE_BIT = 0;
	localparam int CTRL_SERIES_BIT = 1;
	localparam int ST_PICK_BIT = 0;
	localparam int ST_START_BIT = 1;
	localparam int ST_TRIP_BIT = 2;
	localparam int ST_BLOCK_BIT = 3;
	localparam int IRQ_START_BIT = 0;
	localparam int IRQ_TRIP_BIT = 1;
	localparam int IRQ_BLOCK_BIT = 2;
	localparam int IRQ_W = 3;

	typedef enum logic {definite_delay_mode, inverse_delay_mode} pspt_delay_t;
	typedef enum logic {SERIES_IEC, SERIES_IEEE} pspt_series_t;
	typedef enum logic [1:0] {ST_IDLE, ST_BLOCKED, ST_START, ST_TRIP}
		pspt_state_t;
endpackage : pspt_pkg

/* File: rtl/pspt_stage.sv */
// How it works
// - once picked up, release only below 97 percent of the pick-up level.
// - compare measurement with pick-up level every cycle; pick up when exceeded.
// - blocking input is sampled at the start of each processing cycle.
// - pick-up while unblocked raises start and starts the delay timer.
// - pick-up while blocked raises blocked instead of start, nothing further.
// - blocking clears start; release then runs as on pick-up dropout.
// - each blocking emits a timestamped event with start-up value, fault type.
// - instant operation trips in the same cycle as start.
// - definite time trips after the set delay while pick-up holds.
// - inverse time delay depends on measurement relative to pick-up level.
// - in inverse mode the definite delay is a floor; zero removes it.
// - delay type selects definite or inverse, definite after reset.
// - zero definite delay means instant; nonzero means delayed operation.
// - curve series picks IEC or IEEE family, only used in inverse mode.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pspt_stage
#(
	parameter int CYCLE_CLKS_P = pspt_pkg::CYCLE_CLKS
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// measurement source
	input wire logic [pspt_pkg::MEAS_W-1:0] measMag,
	input wire logic [pspt_pkg::FAULT_W-1:0] faultType,
	// blocking matrix
	input wire logic blockIn,
	// stage outputs
	output logic startOut,
	output logic tripOut,
	output logic blockedOut,
	output logic cycleTick,
	// event record
	output logic evtValid,
	output logic [pspt_pkg::TS_W-1:0] evtTime,
	output logic [pspt_pkg::MEAS_W-1:0] evtMeas,
	output logic [pspt_pkg::FAULT_W-1:0] evtFault,
	// interrupt
	output logic irq,
	// avalon-mm slave
	input wire logic [pspt_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pspt_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [pspt_pkg::BE_W-1:0] avs_byteenable,
	output logic [pspt_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest
);
	import pspt_pkg::*;

	localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYCLE_CLKS_P - 1);

	typedef struct packed
	{
		logic [CYC_W-1:0] cycCnt;
		logic tick;
		logic [TS_W-1:0] timeStamp;
		pspt_delay_t delayType;
		pspt_series_t series;
		logic [MEAS_W-1:0] pickup;
		logic [DELAY_W-1:0] delay;
		logic [MEAS_W-1:0] dial;
		pspt_state_t state;
		logic pickedUp;
		logic [MEAS_W-1:0] startMeas;
		logic start;
		logic trip;
		logic blocked;
		logic evtValid;
		logic [TS_W-1:0] evtTime;
		logic [MEAS_W-1:0] evtMeas;
		logic [FAULT_W-1:0] evtFault;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqMask;
		logic irq;
		logic waitReq;
		logic [DATA_W-1:0] rdata;
	} pspt_stage_t;

	pspt_stage_t s;
	pspt_stage_t next_s;

	logic [DELAY_W-1:0] elapsed;
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] increment;

	logic [MEAS_W+PCT_W-1:0] measScaled;
	logic [MEAS_W+PCT_W-1:0] relScaled;
	logic above;
	logic belowRel;
	logic pick;
	logic [MEAS_W-1:0] excess;
	logic [ACC_W:0] accSum;
	logic [ACC_W-1:0] target;
	logic [DELAY_W:0] elapsedNext;
	logic zeroDelay;
	logic delayDone;
	logic invDone;
	logic tripNow;
	logic blkSample;
	logic [IRQ_W-1:0] irqSet;
	logic [IRQ_W-1:0] irqClr;
	logic wrTake;
	logic rdTake;
	logic [DATA_W-1:0] rdMux;
	logic [DATA_W-1:0] wMerged;
	logic [MEAS_W-1:0] capMeas;

	function automatic logic [DATA_W-1:0] mergeBytes(
		input logic [DATA_W-1:0] oldVal,
		input logic [DATA_W-1:0] newVal,
		input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] res;
		res = oldVal;
		for (int i = 0; i < BE_W; i++)
		begin
			if (be[i])
				res[i*8 +: 8] = newVal[i*8 +: 8];
		end
		return res;
	endfunction : mergeBytes

	pspt_delay_timer u_timer
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.tick(s.tick),
		.run(s.start),
		.increment(increment),
		.elapsed(elapsed),
		.acc(acc)
	);

	always_comb
	begin
		next_s = s;
		next_s.evtValid = 1'b0;
		irqSet = '0;

		// processing cycle timebase
		next_s.tick = (s.cycCnt == CYC_LAST);
		if (s.cycCnt == CYC_LAST)
			next_s.cycCnt = '0;
		else
			next_s.cycCnt = s.cycCnt + 1'b1;
		if (s.tick)
			next_s.timeStamp = s.timeStamp + 1'b1;

		// pick-up with hysteresis
		measScaled = measMag * PCT_FULL;
		relScaled = s.pickup * RESET_PCT;
		above = measMag > s.pickup;
		belowRel = measScaled < relScaled;
		pick = s.pickedUp ? !belowRel : above;

		// inverse integrator input, series only matters in inverse mode
		excess = above ? measMag - s.pickup : '0;
		if (s.series == SERIES_IEEE)
			increment = {{(ACC_W-MEAS_W-1){1'b0}}, excess, 1'b0};
		else
			increment = {{(ACC_W-MEAS_W){1'b0}}, excess};
		accSum = {1'b0, acc} + {1'b0, increment};
		target = s.dial * s.pickup;

		elapsedNext = {1'b0, elapsed} + 1'b1;
		zeroDelay = (s.delay == '0);
		delayDone = s.start && (elapsedNext >= {1'b0, s.delay});
		// definite delay is a minimum time here
		invDone = (accSum >= {1'b0, target})
			&& (zeroDelay || delayDone);
		if (s.delayType == definite_delay_mode)
			tripNow = zeroDelay || delayDone;
		else
			tripNow = invDone;

		// blocking is only looked at on the cycle boundary, so a late
		// assertion can miss a trip that lands on the same boundary
		blkSample = blockIn;
		capMeas = s.pickedUp ? s.startMeas : measMag;

		if (s.tick)
		begin
			next_s.pickedUp = pick;
			if (pick && !s.pickedUp)
				next_s.startMeas = measMag;
			if (!pick)
			begin
				next_s.state = ST_IDLE;
			end
			else if (blkSample)
			begin
				next_s.state = ST_BLOCKED;
				if (s.state != ST_BLOCKED)
				begin
					next_s.evtValid = 1'b1;
					next_s.evtTime = s.timeStamp;
					next_s.evtMeas = capMeas;
					next_s.evtFault = faultType;
					irqSet[IRQ_BLOCK_BIT] = 1'b1;
				end
			end
			else if (s.state == ST_TRIP || tripNow)
			begin
				next_s.state = ST_TRIP;
			end
			else
			begin
				next_s.state = ST_START;
			end
		end

		case (next_s.state)
			ST_IDLE:
			begin
				next_s.start = 1'b0;
				next_s.trip = 1'b0;
				next_s.blocked = 1'b0;
			end
			ST_BLOCKED:
			begin
				next_s.start = 1'b0;
				next_s.trip = 1'b0;
				next_s.blocked = 1'b1;
			end
			ST_START:
			begin
				next_s.start = 1'b1;
				next_s.trip = 1'b0;
				next_s.blocked = 1'b0;
			end
			ST_TRIP:
			begin
				next_s.start = 1'b1;
				next_s.trip = 1'b1;
				next_s.blocked = 1'b0;
			end
			default:
			begin
				next_s.start = 1'b0;
				next_s.trip = 1'b0;
				next_s.blocked = 1'b0;
			end
		endcase
		if (next_s.start && !s.start)
			irqSet[IRQ_START_BIT] = 1'b1;
		if (next_s.trip && !s.trip)
			irqSet[IRQ_TRIP_BIT] = 1'b1;

		// bus slave: one wait cycle, then the answer
		rdTake = avs_read && s.waitReq;
		wrTake = avs_write && !s.waitReq;
		next_s.waitReq = !((avs_read || avs_write) && s.waitReq);

		case (avs_address)
			REG_CTRL:
			begin
				rdMux = '0;
				rdMux[CTRL_TYPE_BIT] = s.delayType;
				rdMux[CTRL_SERIES_BIT] = s.series;
			end
			REG_PICKUP:
				rdMux = {{(DATA_W-MEAS_W){1'b0}}, s.pickup};
			REG_DELAY:
				rdMux = {{(DATA_W-DELAY_W){1'b0}}, s.delay};
			REG_DIAL:
				rdMux = {{(DATA_W-MEAS_W){1'b0}}, s.dial};
			REG_STATE:
			begin
				rdMux = '0;
				rdMux[ST_PICK_BIT] = s.pickedUp;
				rdMux[ST_START_BIT] = s.start;
				rdMux[ST_TRIP_BIT] = s.trip;
				rdMux[ST_BLOCK_BIT] = s.blocked;
			end
			REG_IRQ_STAT:
				rdMux = {{(DATA_W-IRQ_W){1'b0}}, s.irqStat};
			REG_IRQ_MASK:
				rdMux = {{(DATA_W-IRQ_W){1'b0}}, s.irqMask};
			REG_TIME:
				rdMux = s.timeStamp;
			default:
				rdMux = '0;
		endcase
		if (rdTake)
			next_s.rdata = rdMux;

		wMerged = mergeBytes(rdMux, avs_writedata, avs_byteenable);
		irqClr = '0;
		if (wrTake)
		begin
			case (avs_address)
				REG_CTRL:
				begin
					next_s.delayType = pspt_delay_t'(wMerged[CTRL_TYPE_BIT]);
					next_s.series = pspt_series_t'(wMerged[CTRL_SERIES_BIT]);
				end
				REG_PICKUP:
					next_s.pickup = wMerged[MEAS_W-1:0];
				REG_DELAY:
				begin
					// out of range clamps to the 1800 s ceiling
					if (wMerged[DATA_W-1:DELAY_W] != '0
						|| wMerged[DELAY_W-1:0] > DELAY_MAX)
						next_s.delay = DELAY_MAX;
					else
						next_s.delay = wMerged[DELAY_W-1:0];
				end
				REG_DIAL:
					next_s.dial = wMerged[MEAS_W-1:0];
				REG_IRQ_STAT:
					irqClr = avs_writedata[IRQ_W-1:0]
						& {IRQ_W{avs_byteenable[0]}};
				REG_IRQ_MASK:
					next_s.irqMask = wMerged[IRQ_W-1:0];
				default:
				begin
				end
			endcase
		end

		// a new event beats a clear in the same cycle
		next_s.irqStat = (s.irqStat & ~irqClr) | irqSet;
		next_s.irq = |(next_s.irqStat & next_s.irqMask);
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.waitReq <= 1'b1;
			s.pickup <= PICKUP_RST;
			s.delay <= DELAY_RST;
			s.dial <= DIAL_RST;
			s.delayType <= definite_delay_mode;
			s.series <= SERIES_IEC;
			s.state <= ST_IDLE;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign startOut = s.start;
	assign tripOut = s.trip;
	assign blockedOut = s.blocked;
	assign cycleTick = s.tick;
	assign evtValid = s.evtValid;
	assign evtTime = s.evtTime;
	assign evtMeas = s.evtMeas;
	assign evtFault = s.evtFault;
	assign irq = s.irq;
	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.waitReq;
endmodule : pspt_stage
